// ==== src/jmpp_pkg.sv ====
/*
 * Shared constants, state types and TAP step function of the JTAG
 * programming port. Assumes both ends are compiled after this package.
 */
`default_nettype none

package jmpp_pkg;

	// ----------------------------------------
	// instruction register
	// ----------------------------------------
	localparam int IR_W = 4;
	localparam logic [3:0] IR_RESET = 4'hC;
	localparam logic [3:0] IR_UNLOCK = 4'h4;
	localparam logic [3:0] IR_CMD = 4'h5;
	localparam logic [3:0] IR_PAGELOAD = 4'h6;
	localparam logic [3:0] IR_PAGEREAD = 4'h7;
	localparam logic [3:0] IR_RST_VAL = 4'hF;
	localparam logic [3:0] IR_CAPTURE = 4'h1;

	// ----------------------------------------
	// data registers
	// ----------------------------------------
	localparam int UNLOCK_W = 16;
	localparam int CMD_W = 15;
	localparam int BYTE_W = 8;
	localparam int BYPASS_W = 1;
	localparam logic [15:0] UNLOCK_SIG = 16'hA370;
	localparam logic [15:0] UNLOCK_RST = 16'h0000;
	localparam logic [14:0] CMD_RST = 15'h0000;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [6:0] CMD_ADDR_HI = 7'h07;
	localparam logic [6:0] CMD_ADDR_LO = 7'h03;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam logic [1:0] DIS_CLR_CLKS = 2'h2;
	localparam int RST_TIMEOUT_CLKS = 64;
	localparam int TCK_HALF = 5;
	localparam int TLR_ONES = 5;
	localparam int PRE_DR = 3;
	localparam int PRE_IR = 4;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [15:0] {
		TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SEL_DR = 16'h0004,
		TAP_CAP_DR = 16'h0008, TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020,
		TAP_PAU_DR = 16'h0040, TAP_EX2_DR = 16'h0080, TAP_UPD_DR = 16'h0100,
		TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
		TAP_EX1_IR = 16'h1000, TAP_PAU_IR = 16'h2000, TAP_EX2_IR = 16'h4000,
		TAP_UPD_IR = 16'h8000
	} jmpp_tap_t;

	typedef enum logic [2:0] {
		H_INIT = 3'h1, H_IDLE = 3'h2, H_RUN = 3'h4
	} jmpp_host_t;

	function automatic jmpp_tap_t tap_next(input jmpp_tap_t s, input logic tms);
		case (s)
			TAP_TLR: tap_next = tms ? TAP_TLR : TAP_RTI;
			TAP_RTI: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_IR: tap_next = tms ? TAP_TLR : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
			default: tap_next = TAP_TLR;
		endcase
	endfunction

endpackage

`default_nettype wire

// ==== src/jmpp_if.sv ====
/*
 * The four test-access pins between programmer and device.
 * Assumes the bench reads tdo only while tdo_oe is high.
 */
`default_nettype none

interface jmpp_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe;

	modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
	modport prog (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface

`default_nettype wire

// ==== src/jmpp_fifo.sv ====
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a power-of-two depth.
 */
`default_nettype none

module jmpp_fifo #(
	parameter int W = 22,
	parameter int D = 16
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);

	if (D < 2 || (1 << AW) != D) begin : g_chk
		$error("jmpp_fifo depth must be a power of two, at least 2");
	end

	logic [W-1:0] mem [D];
	logic [AW:0] wr_reg;
	logic [AW:0] rd_reg;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	// full test needs the extra pointer bit: AW bits alone would wrap D to zero
	assign in_ready = (wr_reg - rd_reg) != (AW+1)'(D);
	assign out_valid = wr_reg != rd_reg;
	assign out_data = mem[rd_reg[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_reg[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			wr_reg <= wr_reg + (AW+1)'(push);
			rd_reg <= rd_reg + (AW+1)'(pop);
		end
	end
endmodule

`default_nettype wire

// ==== src/jmpp_host.sv ====
/*
 * Programmer end: runs queued IR/DR scans on the test-access pins.
 * Assumes the device samples tck with its own faster clock.
 */
`default_nettype none

module jmpp_host #(
	parameter int HALF = jmpp_pkg::TCK_HALF,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rstn,
	jmpp_if.prog link,
	input wire logic job_valid,
	output logic job_ready,
	input wire logic job_is_ir,
	input wire logic [3:0] job_len_m1,
	input wire logic [15:0] job_data,
	output logic res_valid,
	output logic [15:0] res_data,
	output logic busy
);
	if (HALF < 4 || HALF > 256) begin : g_chk
		$error("jmpp_host HALF must be 4 to 256 clocks");
	end

	// ----------------------------------------
	// job queue
	// ----------------------------------------
	logic q_valid;
	logic [20:0] q_data;
	jmpp_pkg::jmpp_host_t st_reg;

	jmpp_fifo #(.W(21), .D(DEPTH)) u_q (
		.clk(clk), .rstn(rstn),
		.in_valid(job_valid), .in_ready(job_ready),
		.in_data({job_is_ir, job_len_m1, job_data}),
		.out_valid(q_valid), .out_ready(st_reg == jmpp_pkg::H_IDLE),
		.out_data(q_data)
	);

	// ----------------------------------------
	// step pattern
	// ----------------------------------------
	function automatic logic step_tms(input logic init, input logic ir, input int len,
			input int s);
		int npre;
		npre = ir ? jmpp_pkg::PRE_IR : jmpp_pkg::PRE_DR;
		if (init)
			step_tms = s < jmpp_pkg::TLR_ONES;
		else if (s < npre)
			step_tms = ir ? (s < 2) : (s == 0);
		else if (s < npre + len)
			step_tms = s == npre + len - 1;
		else
			step_tms = s == npre + len;
	endfunction

	logic tdo_s1, tdo_s2;
	logic tck_reg, tms_reg, tdi_reg;
	logic ir_reg;
	logic [4:0] len_reg;
	logic [15:0] dat_reg;
	logic [4:0] step_reg;
	logic [7:0] div_reg;

	wire is_init = st_reg == jmpp_pkg::H_INIT;
	wire [4:0] npre = ir_reg ? 5'(jmpp_pkg::PRE_IR) : 5'(jmpp_pkg::PRE_DR);
	wire [4:0] last = is_init ? 5'(jmpp_pkg::TLR_ONES) : npre + len_reg + 5'h01;
	wire [4:0] step_n = step_reg + 5'h01;
	wire [4:0] k_now = step_reg - npre;
	wire [4:0] k_n = step_n - npre;
	wire half_end = div_reg == 8'(HALF - 1);
	wire in_shift = !is_init && step_reg >= npre && step_reg < npre + len_reg;

	assign link.tck = tck_reg;
	assign link.tms = tms_reg;
	assign link.tdi = tdi_reg;
	assign busy = st_reg != jmpp_pkg::H_IDLE;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tdo_s1 <= 1'b0;
			tdo_s2 <= 1'b0;
		end else begin
			tdo_s1 <= link.tdo;
			tdo_s2 <= tdo_s1;
		end
	end

	// ----------------------------------------
	// scan engine
	// ----------------------------------------
	// tdo is sampled just before each falling edge of a shift step: the device moved it
	// at the previous falling edge, a full tck period earlier
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= jmpp_pkg::H_INIT;
			tck_reg <= 1'b0;
			tms_reg <= 1'b1;
			tdi_reg <= 1'b0;
			ir_reg <= 1'b0;
			len_reg <= 5'h00;
			dat_reg <= 16'h0000;
			step_reg <= 5'h00;
			div_reg <= 8'h00;
			res_valid <= 1'b0;
			res_data <= 16'h0000;
		end else begin
			res_valid <= 1'b0;
			case (st_reg)
				jmpp_pkg::H_IDLE: begin
					if (q_valid) begin
						ir_reg <= q_data[20];
						len_reg <= {1'b0, q_data[19:16]} + 5'h01;
						dat_reg <= q_data[15:0];
						step_reg <= 5'h00;
						div_reg <= 8'h00;
						tms_reg <= 1'b1;
						res_data <= 16'h0000;
						st_reg <= jmpp_pkg::H_RUN;
					end
				end
				jmpp_pkg::H_INIT, jmpp_pkg::H_RUN: begin
					div_reg <= half_end ? 8'h00 : div_reg + 8'h01;
					if (half_end && !tck_reg) begin
						tck_reg <= 1'b1;
					end else if (half_end) begin
						tck_reg <= 1'b0;
						if (in_shift)
							res_data[k_now[3:0]] <= tdo_s2;
						if (step_reg == last) begin
							res_valid <= !is_init;
							st_reg <= jmpp_pkg::H_IDLE;
						end else begin
							step_reg <= step_n;
							tms_reg <= step_tms(is_init, ir_reg, int'(len_reg), int'(step_n));
							tdi_reg <= dat_reg[k_n[3:0]];
						end
					end
				end
				default: st_reg <= jmpp_pkg::H_INIT;
			endcase
		end
	end
endmodule

`default_nettype wire

// ==== src/jmpp_device.sv ====
/*
 * Device end of the JTAG programming port: TAP controller, instruction
 * register and the reset, unlock, command and byte data registers.
 * Assumes clk is much faster than tck and that the program memory
 * answers pr_data for address pc combinationally.
 */
`default_nettype none

// Behaviour
// - four-bit instruction register, sixteen codes
// - all scan registers shift LSB first
// - only the four test pins needed
// - port needs fuse set, disable bit clear
// - Run-Test/Idle clocks commands and idles
// - code C selects one-bit reset chain
// - chip reset follows chain bit, unlatched
// - chain one acts like reset; then time-out
// - programmer resets chip before unlocking
// - code 4: unlock register, compared on update
// - programming only with exact signature
// - unlock register cleared at power-on
// - code 5: command register, captures result
// - update applies command; idle clocks it
// - code 6: byte register is command low byte
// - page-load byte written soon after update
// - load low then high; pre-increment except first
// - code 7: capture byte, low then high
// - read post-increments after every high byte
module jmpp_device #(
	parameter int RST_TIMEOUT = jmpp_pkg::RST_TIMEOUT_CLKS
) (
	input wire logic clk,
	input wire logic rstn,
	jmpp_if.dev link,
	input wire logic port_enable_fuse,
	input wire logic port_disable_set,
	input wire logic ext_rst_n,
	output logic port_disable_bit,
	output logic chip_reset,
	output logic prog_mode,
	output logic [14:0] mem_cmd,
	output logic mem_cmd_clk,
	input wire logic [14:0] mem_result,
	output logic [15:0] pc,
	output logic pb_wr,
	output logic pb_wr_high,
	output logic [7:0] pb_wr_data,
	input wire logic [15:0] pr_data
);
	if (RST_TIMEOUT < 1 || RST_TIMEOUT > 65535) begin : g_chk
		$error("jmpp_device RST_TIMEOUT out of range");
	end

	function automatic logic [15:0] shift_in(input logic [15:0] v, input logic b,
			input int len);
		logic [15:0] r;
		r = v >> 1;
		r[len-1] = b;
		return r;
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic tck_s1, tck_s2, tck_s3;
	logic tms_s1, tms_s2;
	logic tdi_s1, tdi_s2;
	logic ext_s1, ext_s2;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{tck_s1, tck_s2, tck_s3} <= 3'h0;
			{tms_s1, tms_s2} <= 2'h3;
			{tdi_s1, tdi_s2} <= 2'h0;
			{ext_s1, ext_s2} <= 2'h3;
		end else begin
			{tck_s1, tck_s2, tck_s3} <= {link.tck, tck_s1, tck_s2};
			{tms_s1, tms_s2} <= {link.tms, tms_s1};
			{tdi_s1, tdi_s2} <= {link.tdi, tdi_s1};
			{ext_s1, ext_s2} <= {ext_rst_n, ext_s1};
		end
	end

	// ----------------------------------------
	// port enable and disable bit
	// ----------------------------------------
	logic [1:0] low_reg;
	wire port_active = port_enable_fuse & ~port_disable_bit;

	// set from software wins over the clear by the reset pin
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			port_disable_bit <= 1'b0;
			low_reg <= 2'h0;
		end else begin
			low_reg <= ext_s2 ? 2'h0 : (low_reg == jmpp_pkg::DIS_CLR_CLKS ? low_reg : low_reg + 2'h1);
			if (port_disable_set)
				port_disable_bit <= 1'b1;
			else if (!ext_s2 && low_reg + 2'h1 == jmpp_pkg::DIS_CLR_CLKS)
				port_disable_bit <= 1'b0;
		end
	end

	// ----------------------------------------
	// TAP controller
	// ----------------------------------------
	jmpp_pkg::jmpp_tap_t tap_reg;
	logic [3:0] ir_reg, ir_sh;
	logic [15:0] sh_reg;
	logic rst_chain;
	logic [15:0] unlock_reg;
	logic [14:0] cmd_reg;
	logic cmd_pend;
	logic pl_high, pl_first, pr_high;
	logic tdo_reg, tdo_oe_reg;
	logic [15:0] to_reg;

	wire rise = tck_s2 & ~tck_s3;
	wire fall = ~tck_s2 & tck_s3;
	wire jmpp_pkg::jmpp_tap_t tap_n = jmpp_pkg::tap_next(tap_reg, tms_s2);
	wire cap_dr = rise && tap_reg == jmpp_pkg::TAP_CAP_DR;
	wire sh_dr = rise && tap_reg == jmpp_pkg::TAP_SH_DR;
	wire upd_dr = fall && tap_reg == jmpp_pkg::TAP_UPD_DR;
	wire cap_ir = rise && tap_reg == jmpp_pkg::TAP_CAP_IR;
	wire sh_ir = rise && tap_reg == jmpp_pkg::TAP_SH_IR;
	wire upd_ir = fall && tap_reg == jmpp_pkg::TAP_UPD_IR;
	wire rti_in = rise && tap_reg != jmpp_pkg::TAP_RTI && tap_n == jmpp_pkg::TAP_RTI;
	wire sel_rst = ir_reg == jmpp_pkg::IR_RESET;
	wire sel_unl = ir_reg == jmpp_pkg::IR_UNLOCK;
	wire sel_cmd = ir_reg == jmpp_pkg::IR_CMD;
	wire sel_pl = ir_reg == jmpp_pkg::IR_PAGELOAD;
	wire sel_pr = ir_reg == jmpp_pkg::IR_PAGEREAD;
	wire [6:0] op = sh_reg[14:8];
	wire [15:0] pl_addr = (!pl_high && !pl_first) ? pc + 16'h0001 : pc;
	wire dr_out = sel_rst ? rst_chain : sh_reg[0];

	// data register length follows the instruction
	wire [4:0] dr_len = sel_unl ? 5'(jmpp_pkg::UNLOCK_W) :
		sel_cmd ? 5'(jmpp_pkg::CMD_W) :
		(sel_pl || sel_pr) ? 5'(jmpp_pkg::BYTE_W) : 5'(jmpp_pkg::BYPASS_W);

	assign prog_mode = port_active && unlock_reg == jmpp_pkg::UNLOCK_SIG;
	assign mem_cmd = cmd_reg;
	assign link.tdo = tdo_reg;
	assign link.tdo_oe = tdo_oe_reg;
	// the chain bit drives reset directly, with no update latch
	assign chip_reset = rst_chain | ~ext_s2 | (to_reg != 16'h0000);

	// instruction reset to TLR is not caused by the reset instruction
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tap_reg <= jmpp_pkg::TAP_TLR;
			ir_reg <= jmpp_pkg::IR_RST_VAL;
			ir_sh <= jmpp_pkg::IR_RST_VAL;
		end else if (!port_active) begin
			tap_reg <= jmpp_pkg::TAP_TLR;
			ir_reg <= jmpp_pkg::IR_RST_VAL;
		end else begin
			if (rise)
				tap_reg <= tap_n;
			if (rise && tap_reg == jmpp_pkg::TAP_TLR)
				ir_reg <= jmpp_pkg::IR_RST_VAL;
			else if (upd_ir)
				ir_reg <= ir_sh;
			if (cap_ir)
				ir_sh <= jmpp_pkg::IR_CAPTURE;
			else if (sh_ir)
				ir_sh <= {tdi_s2, ir_sh[3:1]};
		end
	end

	// ----------------------------------------
	// data registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sh_reg <= 16'h0000;
			rst_chain <= 1'b0;
			unlock_reg <= jmpp_pkg::UNLOCK_RST;
			cmd_reg <= jmpp_pkg::CMD_RST;
		end else begin
			if (cap_dr && sel_cmd)
				sh_reg <= {1'b0, mem_result};
			else if (cap_dr && sel_pr && prog_mode)
				sh_reg <= {8'h00, pr_high ? pr_data[15:8] : pr_data[7:0]};
			else if (cap_dr && !sel_rst)
				sh_reg <= 16'h0000;
			else if (sh_dr && !sel_rst)
				sh_reg <= shift_in(sh_reg, tdi_s2, int'(dr_len));
			if (sh_dr && sel_rst)
				rst_chain <= tdi_s2;
			if (upd_dr && sel_unl)
				unlock_reg <= sh_reg;
			if (upd_dr && sel_cmd && prog_mode)
				cmd_reg <= sh_reg[14:0];
			else if (upd_dr && sel_pl && prog_mode)
				cmd_reg[7:0] <= sh_reg[7:0];
		end
	end

	// ----------------------------------------
	// command clock, page load and page read
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmd_pend <= 1'b0;
			mem_cmd_clk <= 1'b0;
			pc <= jmpp_pkg::PC_RST;
			pl_high <= 1'b0;
			pl_first <= 1'b1;
			pr_high <= 1'b0;
			pb_wr <= 1'b0;
			pb_wr_high <= 1'b0;
			pb_wr_data <= 8'h00;
		end else begin
			mem_cmd_clk <= 1'b0;
			pb_wr <= 1'b0;
			if (upd_dr && sel_cmd && prog_mode) begin
				cmd_pend <= 1'b1;
				if (op == jmpp_pkg::CMD_ADDR_HI)
					pc[15:8] <= sh_reg[7:0];
				else if (op == jmpp_pkg::CMD_ADDR_LO)
					pc[7:0] <= sh_reg[7:0];
			end else if (rti_in && sel_cmd && cmd_pend) begin
				cmd_pend <= 1'b0;
				mem_cmd_clk <= prog_mode;
			end
			if (upd_ir) begin
				pl_high <= 1'b0;
				pl_first <= 1'b1;
				pr_high <= 1'b0;
			end else if (upd_dr && sel_pl && prog_mode) begin
				// written the next clock, far inside the tck budget
				pc <= pl_addr;
				pb_wr <= 1'b1;
				pb_wr_high <= pl_high;
				pb_wr_data <= sh_reg[7:0];
				pl_high <= ~pl_high;
				pl_first <= 1'b0;
			end else if (cap_dr && sel_pr && prog_mode) begin
				pr_high <= ~pr_high;
				if (pr_high)
					pc <= pc + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// reset time-out and tdo
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			to_reg <= 16'(RST_TIMEOUT);
			tdo_reg <= 1'b0;
			tdo_oe_reg <= 1'b0;
		end else begin
			if (rst_chain || !ext_s2)
				to_reg <= 16'(RST_TIMEOUT);
			else if (to_reg != 16'h0000)
				to_reg <= to_reg - 16'h0001;
			if (fall) begin
				tdo_oe_reg <= port_active && (tap_reg == jmpp_pkg::TAP_SH_DR ||
					tap_reg == jmpp_pkg::TAP_SH_IR);
				tdo_reg <= tap_reg == jmpp_pkg::TAP_SH_IR ? ir_sh[0] : dr_out;
			end
		end
	end
endmodule

`default_nettype wire

// ==== sim/jmpp_assertions.sv ====
/*
 * Wire checks on the four test pins, with a shadow TAP state.
 * Assumes the host keeps tck phases of five clk and drives it from clk.
 */
`default_nettype none

module jmpp_assertions (
	input wire logic clk,
	input wire logic rstn,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// shadow tap state
	// ----------------------------------------
	logic tck_q;
	logic last_tdi;
	logic [4:0] bitn;
	logic [3:0] ir_sh;
	logic [3:0] ir_cur;
	jmpp_pkg::jmpp_tap_t st;
	wire logic rise = tck & ~tck_q;
	wire logic sh_dr = (st == jmpp_pkg::TAP_SH_DR);
	wire logic sh_ir = (st == jmpp_pkg::TAP_SH_IR);
	wire logic ex1 = (st == jmpp_pkg::TAP_EX1_DR) || (st == jmpp_pkg::TAP_EX1_IR);
	wire logic bypass = (ir_cur == jmpp_pkg::IR_RST_VAL);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tck_q <= 1'b0;
			st <= jmpp_pkg::TAP_TLR;
			bitn <= 5'h00;
			ir_sh <= 4'h0;
			ir_cur <= jmpp_pkg::IR_RST_VAL;
			last_tdi <= 1'b0;
		end else begin
			tck_q <= tck;
			if (rise) begin
				st <= jmpp_pkg::tap_next(st, tms);
				last_tdi <= tdi;
				bitn <= (sh_dr || sh_ir) ? bitn + 5'h01 : 5'h00;
				if (sh_ir) ir_sh <= {tdi, ir_sh[3:1]};
				if (st == jmpp_pkg::TAP_UPD_IR) ir_cur <= ir_sh;
				if (st == jmpp_pkg::TAP_TLR) ir_cur <= jmpp_pkg::IR_RST_VAL;
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	property p_tck_high;
		$rose(tck) |-> tck [*5] ##1 !tck;
	endproperty
	a_tck_high: assert property (p_tck_high) else $error("tck high phase wrong");

	property p_tck_low;
		$fell(tck) |-> !tck [*5];
	endproperty
	a_tck_low: assert property (p_tck_low) else $error("tck low phase short");

	property p_tdo_edge;
		$changed(tdo) |-> !$past(tck);
	endproperty
	a_tdo_edge: assert property (p_tdo_edge) else $error("tdo moved on rising tck");

	property p_oe_on;
		$rose(tdo_oe) |-> sh_dr || sh_ir;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("tdo_oe rose outside shift");

	property p_oe_off;
		$fell(tdo_oe) |-> ex1;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("tdo_oe fell outside exit");

	property p_ir_cap;
		rise && sh_ir && bitn < 5'h04 |-> tdo == (bitn == 5'h00);
	endproperty
	a_ir_cap: assert property (p_ir_cap) else $error("ir capture pattern wrong");

	property p_bypass;
		rise && sh_dr && bypass |-> tdo == ((bitn == 5'h00) ? 1'b0 : last_tdi);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass bit order wrong");

	property p_rti_quiet;
		rise && st == jmpp_pkg::TAP_RTI |-> !tdo_oe;
	endproperty
	a_rti_quiet: assert property (p_rti_quiet) else $error("tdo driven in idle");
endmodule

`default_nettype wire

// ==== sim/jtag_memory_programming_port_tb_top.sv ====
/*
 * Bench: host and device joined by the pin interface; jobs go in at the
 * host, effects are read at the device. Assumes a short reset time-out.
 */
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module jtag_memory_programming_port_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk, rstn, job_valid, job_ready, job_is_ir, res_valid, busy;
	logic [3:0] job_len_m1;
	logic [15:0] job_data, res_data, pc, pr_data;
	logic port_enable_fuse, port_disable_set, ext_rst_n, port_disable_bit;
	logic chip_reset, prog_mode, mem_cmd_clk, pb_wr, pb_wr_high;
	logic [14:0] mem_cmd, mem_result;
	logic [7:0] pb_wr_data;
	logic [24:0] wq[$];
	int err_count, checks, cyc, n_cmd, n_res;

	jmpp_if jmpp_if_i ();
	jmpp_host #(.HALF(5), .DEPTH(16)) jmpp_host_i (.clk(clk), .rstn(rstn),
		.link(jmpp_if_i), .job_valid(job_valid), .job_ready(job_ready),
		.job_is_ir(job_is_ir), .job_len_m1(job_len_m1), .job_data(job_data),
		.res_valid(res_valid), .res_data(res_data), .busy(busy));
	jmpp_device #(.RST_TIMEOUT(4)) jmpp_device_i (.clk(clk), .rstn(rstn),
		.link(jmpp_if_i), .port_enable_fuse(port_enable_fuse),
		.port_disable_set(port_disable_set), .ext_rst_n(ext_rst_n),
		.port_disable_bit(port_disable_bit), .chip_reset(chip_reset),
		.prog_mode(prog_mode), .mem_cmd(mem_cmd), .mem_cmd_clk(mem_cmd_clk),
		.mem_result(mem_result), .pc(pc), .pb_wr(pb_wr), .pb_wr_high(pb_wr_high),
		.pb_wr_data(pb_wr_data), .pr_data(pr_data));
	jmpp_assertions jmpp_assertions_i (.clk(clk), .rstn(rstn), .tck(jmpp_if_i.tck),
		.tms(jmpp_if_i.tms), .tdi(jmpp_if_i.tdi), .tdo(jmpp_if_i.tdo),
		.tdo_oe(jmpp_if_i.tdo_oe));

	// ----------------------------------------
	// memory model and expectations
	// ----------------------------------------
	function automatic logic [15:0] rd_word(input logic [15:0] a);
		return {a[7:0] ^ 8'h5A, a[15:8] ^ 8'hC3};
	endfunction

	function automatic logic [7:0] rd_byte(input logic [15:0] base, input int k);
		logic [15:0] w;
		w = rd_word(base + 16'(k / 2));
		return (k % 2) ? w[15:8] : w[7:0];
	endfunction

	always @(negedge clk) pr_data = rd_word(pc);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (mem_cmd_clk === 1'b1) n_cmd++;
		if (res_valid === 1'b1) n_res++;
		if (pb_wr === 1'b1) wq.push_back({pc, pb_wr_high, pb_wr_data});
		if (cyc == 60000) begin
			err_count++;
			give_verdict();
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// entered and left at a falling edge
	task automatic scan(input logic ir, input logic [3:0] lm1, input logic [15:0] d,
		output logic [15:0] r);
		int t;
		job_is_ir = ir;
		job_len_m1 = lm1;
		job_data = d;
		job_valid = 1'b1;
		t = 0;
		while (job_ready !== 1'b1 && t < 100) begin
			@(negedge clk);
			t++;
		end
		@(negedge clk);
		job_valid = 1'b0;
		t = 0;
		while (res_valid !== 1'b1 && t < 3000) begin
			@(negedge clk);
			t++;
		end
		if (t >= 3000) err_count++;
		r = res_data;
		@(negedge clk);
	endtask

	task automatic ir(input logic [3:0] code);
		logic [15:0] r;
		scan(1'b1, 4'h3, {12'h000, code}, r);
		`CHK(r[3:0], jmpp_pkg::IR_CAPTURE)
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [15:0] r, base, d;
		logic [7:0] b[6];
		int n, k, c0;
		void'($urandom(71));
		{rstn, job_valid, job_is_ir, port_disable_set} = 4'h0;
		{job_len_m1, job_data, mem_result} = '0;
		port_enable_fuse = 1'b1;
		ext_rst_n = 1'b1;
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		`CHK(chip_reset, 1'b1)
		`CHK(prog_mode, 1'b0)
		ir(jmpp_pkg::IR_RST_VAL);
		d = 16'($urandom);
		scan(1'b0, 4'h7, d, r);
		`CHK(r[7:0], {d[6:0], 1'b0})
		ir(jmpp_pkg::IR_RESET);
		scan(1'b0, 4'h0, 16'h0001, r);
		`CHK(chip_reset, 1'b1)
		ir(jmpp_pkg::IR_CMD);
		scan(1'b0, 4'hE, {1'b0, jmpp_pkg::CMD_ADDR_HI, 8'h5A}, r);
		`CHK(pc, jmpp_pkg::PC_RST)
		ir(jmpp_pkg::IR_PAGELOAD);
		scan(1'b0, 4'h7, 16'h00A5, r);
		`CHK(wq.size(), 0)
		ir(jmpp_pkg::IR_PAGEREAD);
		scan(1'b0, 4'h7, 16'h0000, r);
		`CHK(r[7:0], 8'h00)
		ir(jmpp_pkg::IR_UNLOCK);
		scan(1'b0, 4'hF, jmpp_pkg::UNLOCK_SIG ^ (16'h0001 << ($urandom % 16)), r);
		`CHK(prog_mode, 1'b0)
		scan(1'b0, 4'hF, jmpp_pkg::UNLOCK_SIG, r);
		`CHK(prog_mode, 1'b1)
		ir(jmpp_pkg::IR_CMD);
		base = 16'($urandom);
		c0 = n_cmd;
		scan(1'b0, 4'hE, {1'b0, jmpp_pkg::CMD_ADDR_HI, base[15:8]}, r);
		scan(1'b0, 4'hE, {1'b0, jmpp_pkg::CMD_ADDR_LO, base[7:0]}, r);
		`CHK(pc, base)
		mem_result = 15'($urandom);
		d = {1'b0, 7'h33, 8'($urandom)};
		scan(1'b0, 4'hE, d, r);
		`CHK(r[14:0], mem_result)
		`CHK(mem_cmd, d[14:0])
		`CHK(n_cmd - c0, 3)
		ir(jmpp_pkg::IR_PAGELOAD);
		wq.delete();
		for (k = 0; k < 6; k++) begin
			b[k] = 8'($urandom);
			scan(1'b0, 4'h7, {8'h00, b[k]}, r);
		end
		`CHK(wq.size(), 6)
		for (k = 0; k < 6; k++) begin
			`CHK(wq[k], {base + 16'(k / 2), 1'(k % 2), b[k]})
		end
		`CHK(pc, base + 16'h0002)
		ir(jmpp_pkg::IR_CMD);
		scan(1'b0, 4'hE, {1'b0, jmpp_pkg::CMD_ADDR_HI, base[15:8]}, r);
		scan(1'b0, 4'hE, {1'b0, jmpp_pkg::CMD_ADDR_LO, base[7:0]}, r);
		ir(jmpp_pkg::IR_PAGEREAD);
		for (k = 0; k < 4; k++) begin
			scan(1'b0, 4'h7, 16'h0000, r);
			`CHK(r[7:0], rd_byte(base, k))
		end
		`CHK(pc, base + 16'h0002)
		// fill the job queue until it refuses, then let it drain
		{job_is_ir, job_len_m1, job_data} = {1'b1, 4'h3, 16'h000F};
		c0 = n_res;
		n = 0;
		job_valid = 1'b1;
		while (job_ready === 1'b1 && n < 40) begin
			n++;
			@(negedge clk);
		end
		job_valid = 1'b0;
		`CHK(n inside {16, 17}, 1'b1)
		k = 0;
		while (n_res - c0 < n && k < 5000) begin
			@(negedge clk);
			k++;
		end
		repeat (5) @(negedge clk);
		`CHK(n_res - c0, n)
		`CHK(busy, 1'b0)
		ir(jmpp_pkg::IR_RESET);
		scan(1'b0, 4'h0, 16'h0000, r);
		`CHK(chip_reset, 1'b0)
		port_disable_set = 1'b1;
		@(negedge clk);
		port_disable_set = 1'b0;
		`CHK(port_disable_bit, 1'b1)
		`CHK(prog_mode, 1'b0)
		ext_rst_n = 1'b0;
		repeat (6) @(negedge clk);
		`CHK(port_disable_bit, 1'b0)
		`CHK(chip_reset, 1'b1)
		`CHK(prog_mode, 1'b1)
		port_enable_fuse = 1'b0;
		@(negedge clk);
		`CHK(prog_mode, 1'b0)
		port_enable_fuse = 1'b1;
		ext_rst_n = 1'b1;
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		`CHK(prog_mode, 1'b0)
		ir(jmpp_pkg::IR_UNLOCK);
		scan(1'b0, 4'hF, jmpp_pkg::UNLOCK_SIG, r);
		`CHK(prog_mode, 1'b1)
		give_verdict();
	end
endmodule

`default_nettype wire
